// ---- verilog/cmb_defs.svh ----
// constants of the cylinder holding-register bank and its serial link
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH

// ----------------------------------------------------------------
// clock, link and legionella timing
// ----------------------------------------------------------------
`define CMB_CLK_HZ 32'h0BEB_C200
`define CMB_BAUD 32'h0000_2580
`define CMB_GAP_TENTHS 32'h0000_0023
`define CMB_SEC_PER_HOUR 32'h0000_0E10
`define CMB_SEC_PER_WEEK 32'h0009_3A80
`define CMB_OUT_HOURS 32'h0000_0018
`define CMB_BOT_WEEKS 32'h0000_0002

// ----------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------
`define CMB_REG_DEMAND 4'h0
`define CMB_REG_SET_TEMP 4'h1
`define CMB_REG_TARGET_CHG 4'h2
`define CMB_REG_SOURCE 4'h3
`define CMB_REG_IMMERSION 4'h4
`define CMB_REG_TOP 4'h5
`define CMB_REG_FEEDBACK 4'h6
`define CMB_REG_MID 4'h7
`define CMB_REG_BOTTOM 4'h8
`define CMB_REG_CHARGE 4'h9
`define CMB_REG_CLEANSE 4'hA
`define CMB_REG_NODE_ADDR 4'hB
`define CMB_REG_COUNT 17'h0_000C

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define CMB_DEMAND_RST 16'h0000
`define CMB_SET_TEMP_RST 16'h01F4
`define CMB_TARGET_CHG_RST 16'h0064
`define CMB_SOURCE_RST 16'h0000
`define CMB_NODE_ADDR_RST 16'h0089
`define CMB_NODE_ADDR_MAX 16'h00FF
`define CMB_DEMAND_ON 16'h0001
`define CMB_BAND_LOW 16'h00C8
`define CMB_BAND_HIGH 16'h01C2
`define CMB_CLEANSE_TEMP 16'h024E
`define CMB_FULL_CHARGE 16'h0064

// ----------------------------------------------------------------
// frame protocol
// ----------------------------------------------------------------
`define CMB_FC_READ_HOLD 8'h03
`define CMB_FC_WRITE_ONE 8'h06
`define CMB_EXC_FLAG 8'h80
`define CMB_EXC_FUNC 8'h01
`define CMB_EXC_ADDR 8'h02
`define CMB_EXC_VALUE 8'h03
`define CMB_CRC_INIT 16'hFFFF
`define CMB_CRC_POLY 16'hA001
`define CMB_REQ_LEN 4'h8
`define CMB_EXC_LEN 5'h05
`define CMB_ECHO_LEN 5'h08
`define CMB_READ_HDR 5'h05

`endif

// ---- verilog/cmb_pkg.sv ----
// types of the cylinder holding-register bank
package cmb_pkg;

  // ----------------------------------------------------------------
  // cylinder configuration and link phase
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    low_temp_heat_pump_config,
    high_temp_heat_pump_config,
    indirect_config,
    direct_electric_config
  } cmb_cfg_e;

  typedef enum logic {lk_rx, lk_tx} cmb_link_e;

  // ----------------------------------------------------------------
  // whole state of the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    cmb_link_e st;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic frame_bad;
    logic [19:0] gap_cnt;
    logic [3:0] rx_len;
    logic [7:0][7:0] rx_buf;
    logic [15:0] crc_rx;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic [4:0] tx_idx;
    logic [4:0] tx_len;
    logic [15:0] crc_tx;
    logic tx_line;
    logic tx_oe;
    logic [7:0] rsp_fc;
    logic [7:0] rsp_exc;
    logic [3:0] rsp_start;
    logic [3:0] rsp_cnt;
    logic [15:0] demand;
    logic [15:0] set_temp;
    logic [15:0] target_chg;
    logic [15:0] source;
    logic [15:0] node_addr;
    logic immersion;
    logic relay;
    logic cleanse;
    logic [27:0] sec_cnt;
    logic [20:0] out_s;
    logic [20:0] bot_s;
  } cmb_state_s;

endpackage

// ---- verilog/cmb_register_bank.sv ----
// holding-register bank of the cylinder controller with its serial frame slave
`timescale 1ns/10ps
`include "cmb_defs.svh"

module cmb_register_bank #(
  parameter logic [15:0] BIT_CYCLES = 16'(`CMB_CLK_HZ / `CMB_BAUD),
  parameter logic [19:0] GAP_CYCLES = 20'(`CMB_GAP_TENTHS * (`CMB_CLK_HZ / `CMB_BAUD) / 10),
  parameter logic [27:0] SEC_CYCLES = 28'(`CMB_CLK_HZ),
  parameter logic [20:0] OUT_LIMIT_S = 21'(`CMB_OUT_HOURS * `CMB_SEC_PER_HOUR),
  parameter logic [20:0] BOT_LIMIT_S = 21'(`CMB_BOT_WEEKS * `CMB_SEC_PER_WEEK)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rs_rx,
  output logic rs_tx,
  output logic rs_de,
  input wire cmb_pkg::cmb_cfg_e cfg,
  input wire logic [15:0] top_temp,
  input wire logic [15:0] feedback_temp,
  input wire logic [15:0] mid_temp,
  input wire logic [15:0] bottom_temp,
  input wire logic [15:0] charge_pct,
  output logic immersion_on,
  output logic relay_on,
  output logic cleanse_required,
  output logic heat_demand_on
);

  cmb_pkg::cmb_state_s s;
  cmb_pkg::cmb_state_s n;
  logic heat_call;
  logic [1:0] use_src;
  logic tick;
  logic out_set;
  logic bot_set;
  logic clr_ev;
  logic frame_end;
  logic frame_ok;
  logic bcast;
  logic [7:0] fc;
  logic [7:0] exc;
  logic [7:0] rb;
  logic [15:0] start;
  logic [15:0] val;
  logic [16:0] span;
  logic [4:0] k;
  logic [3:0] ri;
  logic [15:0] rd_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CMB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic src_valid(input cmb_pkg::cmb_cfg_e c, input logic [15:0] v);
    unique case (c)
      cmb_pkg::low_temp_heat_pump_config: return v <= 16'h0002;
      cmb_pkg::high_temp_heat_pump_config, cmb_pkg::indirect_config: return v <= 16'h0001;
      cmb_pkg::direct_electric_config: return v == 16'h0000;
    endcase
  endfunction

  // {electric, pump or indirect}; unusable codes act as 0
  function automatic logic [1:0] src_use(input cmb_pkg::cmb_cfg_e c, input logic [15:0] v);
    logic [15:0] w;
    w = src_valid(c, v) ? v : 16'h0000;
    if (c == cmb_pkg::direct_electric_config) begin
      return 2'b10;
    end
    unique case (w[1:0])
      2'b00: return 2'b01;
      2'b01: return 2'b10;
      default: return 2'b11;
    endcase
  endfunction

  function automatic logic in_band(input logic [15:0] t);
    return (t >= `CMB_BAND_LOW) && (t <= `CMB_BAND_HIGH);
  endfunction

  function automatic logic [15:0] reg_read(input logic [3:0] a, input cmb_pkg::cmb_state_s q);
    unique case (a)
      `CMB_REG_DEMAND: return q.demand;
      `CMB_REG_SET_TEMP: return q.set_temp;
      `CMB_REG_TARGET_CHG: return q.target_chg;
      `CMB_REG_SOURCE: return q.source;
      `CMB_REG_IMMERSION: return {15'h0000, q.immersion};
      `CMB_REG_TOP: return top_temp;
      `CMB_REG_FEEDBACK: return feedback_temp;
      `CMB_REG_MID: return mid_temp;
      `CMB_REG_BOTTOM: return bottom_temp;
      `CMB_REG_CHARGE: return charge_pct;
      `CMB_REG_CLEANSE: return {15'h0000, q.cleanse};
      `CMB_REG_NODE_ADDR: return q.node_addr;
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    heat_call = (s.demand == `CMB_DEMAND_ON) && (charge_pct < s.target_chg);
    use_src = src_use(cfg, s.source);
    tick = (s.sec_cnt == SEC_CYCLES - 28'h000_0001);
    out_set = tick && in_band(top_temp) && (s.out_s == OUT_LIMIT_S);
    bot_set = tick && in_band(bottom_temp) && (s.bot_s == BOT_LIMIT_S);
    clr_ev = (charge_pct >= `CMB_FULL_CHARGE) && (top_temp > `CMB_CLEANSE_TEMP);
    frame_end = 1'b0;
    frame_ok = 1'b0;
    bcast = (s.rx_buf[0] == 8'h00);
    fc = s.rx_buf[1];
    start = {s.rx_buf[2], s.rx_buf[3]};
    val = {s.rx_buf[4], s.rx_buf[5]};
    span = {1'b0, start} + {1'b0, val};
    exc = 8'h00;
    rb = 8'h00;
    k = 5'h00;
    ri = 4'h0;
    rd_word = 16'h0000;

    // heat outputs follow the heat call (demand on, charge below target) and the decoded source
    n.immersion = heat_call && use_src[1];
    n.relay = heat_call && use_src[0];
    if (!src_valid(cfg, s.source)) begin
      n.source = `CMB_SOURCE_RST;
    end

    // legionella watch; seconds keep the long counters narrow
    n.sec_cnt = tick ? 28'h000_0000 : s.sec_cnt + 28'h000_0001;
    if (tick) begin
      n.out_s = !in_band(top_temp) ? 21'h00_0000 :
                (s.out_s > OUT_LIMIT_S) ? s.out_s : s.out_s + 21'h00_0001;
      n.bot_s = !in_band(bottom_temp) ? 21'h00_0000 :
                (s.bot_s > BOT_LIMIT_S) ? s.bot_s : s.bot_s + 21'h00_0001;
    end
    if (clr_ev) begin
      n.out_s = 21'h00_0000;
      n.bot_s = 21'h00_0000;
    end
    // a new crossing beats a same-cycle clear
    n.cleanse = out_set || bot_set || (s.cleanse && !clr_ev);

    unique case (s.st)
      cmb_pkg::lk_rx: begin
        // receiver, sampled mid-bit
        if (!s.rx_busy) begin
          if (!rs_rx) begin
            n.rx_busy = 1'b1;
            n.rx_cnt = BIT_CYCLES >> 1;
            n.rx_bit = 4'h0;
          end
        end else if (s.rx_cnt != 16'h0000) begin
          n.rx_cnt = s.rx_cnt - 16'h0001;
        end else begin
          n.rx_cnt = BIT_CYCLES - 16'h0001;
          n.rx_bit = s.rx_bit + 4'h1;
          if (s.rx_bit == 4'h0) begin
            n.rx_busy = !rs_rx;
          end else if (s.rx_bit != 4'h9) begin
            n.rx_sh = {rs_rx, s.rx_sh[7:1]};
          end else begin
            n.rx_busy = 1'b0;
            if (!rs_rx || s.rx_len == `CMB_REQ_LEN) begin
              n.frame_bad = 1'b1;
            end else begin
              n.rx_buf[s.rx_len[2:0]] = s.rx_sh;
              n.crc_rx = crc_step(s.crc_rx, s.rx_sh);
              n.rx_len = s.rx_len + 4'h1;
            end
          end
        end
        // 3.5 bit times of silence close a frame
        if (s.rx_busy || !rs_rx) begin
          n.gap_cnt = 20'h0_0000;
        end else if (s.gap_cnt != GAP_CYCLES) begin
          n.gap_cnt = s.gap_cnt + 20'h0_0001;
        end
        frame_end = !s.rx_busy && rs_rx && (s.gap_cnt == GAP_CYCLES - 20'h0_0001);
        frame_ok = frame_end && !s.frame_bad && (s.rx_len == `CMB_REQ_LEN) &&
                   (s.crc_rx == 16'h0000) &&
                   (bcast || {8'h00, s.rx_buf[0]} == s.node_addr);
        if (frame_end) begin
          n.rx_len = 4'h0;
          n.frame_bad = 1'b0;
          n.crc_rx = `CMB_CRC_INIT;
        end
        if (frame_ok) begin
          if (fc == `CMB_FC_READ_HOLD) begin
            if (val == 16'h0000 || val > 16'(`CMB_REG_COUNT)) begin
              exc = `CMB_EXC_VALUE;
            end else if (span > `CMB_REG_COUNT) begin
              exc = `CMB_EXC_ADDR;
            end
          end else if (fc == `CMB_FC_WRITE_ONE) begin
            if (start >= 16'(`CMB_REG_COUNT) ||
                (start >= 16'(`CMB_REG_TOP) && start <= 16'(`CMB_REG_CLEANSE))) begin
              exc = `CMB_EXC_ADDR;
            end else if (start == 16'(`CMB_REG_NODE_ADDR) &&
                         (val == 16'h0000 || val > `CMB_NODE_ADDR_MAX)) begin
              exc = `CMB_EXC_VALUE;
            end else begin
              unique case (start[3:0])
                `CMB_REG_DEMAND: n.demand = val;
                `CMB_REG_SET_TEMP: n.set_temp = val;
                `CMB_REG_TARGET_CHG: n.target_chg = val;
                `CMB_REG_SOURCE: n.source = src_valid(cfg, val) ? val : `CMB_SOURCE_RST;
                `CMB_REG_NODE_ADDR: n.node_addr = val;
                default: n.demand = s.demand;
              endcase
            end
          end else begin
            exc = `CMB_EXC_FUNC;
          end
          // broadcasts are acted on but never answered
          if (!bcast) begin
            n.st = cmb_pkg::lk_tx;
            n.tx_oe = 1'b1;
            n.tx_idx = 5'h00;
            n.crc_tx = `CMB_CRC_INIT;
            n.rsp_fc = fc;
            n.rsp_exc = exc;
            n.rsp_start = start[3:0];
            n.rsp_cnt = val[3:0];
            n.tx_len = (exc != 8'h00) ? `CMB_EXC_LEN :
                       (fc == `CMB_FC_READ_HOLD) ? `CMB_READ_HDR + {val[3:0], 1'b0} :
                       `CMB_ECHO_LEN;
          end
        end
      end
      cmb_pkg::lk_tx: begin
        // answer byte by index; registers are read live as bytes leave
        k = s.tx_idx - 5'h03;
        ri = s.rsp_start + k[4:1];
        rd_word = reg_read(ri, s);
        if (s.rsp_exc != 8'h00) begin
          rb = (s.tx_idx == 5'h00) ? s.rx_buf[0] :
               (s.tx_idx == 5'h01) ? (s.rsp_fc | `CMB_EXC_FLAG) : s.rsp_exc;
        end else if (s.rsp_fc == `CMB_FC_READ_HOLD) begin
          if (s.tx_idx == 5'h00) begin
            rb = s.rx_buf[0];
          end else if (s.tx_idx == 5'h01) begin
            rb = s.rsp_fc;
          end else if (s.tx_idx == 5'h02) begin
            rb = {3'b000, s.rsp_cnt, 1'b0};
          end else begin
            rb = k[0] ? rd_word[7:0] : rd_word[15:8];
          end
        end else begin
          rb = s.rx_buf[s.tx_idx[2:0]];
        end
        if (s.tx_idx == s.tx_len - 5'h02) begin
          rb = s.crc_tx[7:0];
        end else if (s.tx_idx == s.tx_len - 5'h01) begin
          rb = s.crc_tx[15:8];
        end
        if (!s.tx_busy) begin
          if (s.tx_idx == s.tx_len) begin
            n.st = cmb_pkg::lk_rx;
            n.tx_oe = 1'b0;
            n.gap_cnt = 20'h0_0000;
          end else begin
            if (s.tx_idx < s.tx_len - 5'h02) begin
              n.crc_tx = crc_step(s.crc_tx, rb);
            end
            n.tx_sh = {1'b1, rb, 1'b0};
            n.tx_line = 1'b0;
            n.tx_busy = 1'b1;
            n.tx_bit = 4'h0;
            n.tx_cnt = BIT_CYCLES - 16'h0001;
          end
        end else if (s.tx_cnt != 16'h0000) begin
          n.tx_cnt = s.tx_cnt - 16'h0001;
        end else if (s.tx_bit == 4'h9) begin
          n.tx_busy = 1'b0;
          n.tx_idx = s.tx_idx + 5'h01;
        end else begin
          n.tx_sh = {1'b1, s.tx_sh[9:1]};
          n.tx_line = s.tx_sh[1];
          n.tx_bit = s.tx_bit + 4'h1;
          n.tx_cnt = BIT_CYCLES - 16'h0001;
        end
      end
    endcase

    if (!rst_b) begin
      n = '0;
      n.st = cmb_pkg::lk_rx;
      n.crc_rx = `CMB_CRC_INIT;
      n.tx_line = 1'b1;
      n.demand = `CMB_DEMAND_RST;
      n.set_temp = `CMB_SET_TEMP_RST;
      n.target_chg = `CMB_TARGET_CHG_RST;
      n.source = `CMB_SOURCE_RST;
      n.node_addr = `CMB_NODE_ADDR_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    s <= n;
  end

  assign rs_tx = s.tx_line;
  assign rs_de = s.tx_oe;
  assign immersion_on = s.immersion;
  assign relay_on = s.relay;
  assign cleanse_required = s.cleanse;
  assign heat_demand_on = (s.demand == `CMB_DEMAND_ON);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_idle_no_heat: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s.demand != `CMB_DEMAND_ON) |=> !immersion_on && !relay_on)
    else $error("heat output active while demand off");

  a_on_charges: assert property (@(posedge sys_clk) disable iff (!rst_b)
    heat_call |=> (immersion_on || relay_on))
    else $error("no heat source driven while charging");

  a_heater_call: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (heat_call && use_src[1]) |=> immersion_on)
    else $error("electric call did not energise heater");

  a_relay_call: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (heat_call && use_src[0]) |=> relay_on)
    else $error("pump or indirect call did not close relay");

  a_source_legal: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($past(cfg) == cfg) |-> src_valid(cfg, s.source))
    else $error("heat source holds a code with no function");

  a_addr_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 (s.node_addr != 16'h0000) && (s.node_addr <= `CMB_NODE_ADDR_MAX))
    else $error("node address out of range");

  a_cleanse_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (out_set || bot_set) |=> cleanse_required ##1 (cleanse_required || $past(clr_ev)))
    else $error("cleanse flag not raised after band interval");

  a_cleanse_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clr_ev && !out_set && !bot_set) |=> !cleanse_required)
    else $error("cleanse flag not cleared after hot full charge");

  a_ro_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (frame_ok && !bcast && fc == `CMB_FC_WRITE_ONE && start >= 16'(`CMB_REG_TOP) &&
     start <= 16'(`CMB_REG_CLEANSE)) |=> rs_de && s.rsp_exc == `CMB_EXC_ADDR &&
     $stable(s.demand))
    else $error("write to read-only register not refused");

  a_de_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(rs_de) |-> rs_tx && $past(rs_tx) && $past(s.tx_idx) == $past(s.tx_len))
    else $error("driver released mid character");

endmodule

// ---- verification/cmb_master_model.sv ----
// serial frame master model that polls the cylinder register bank
`timescale 1ns/10ps
module cmb_master_model #(
  parameter int BIT = 10
) (
  input wire logic sys_clk,
  input wire logic rs_tx,
  input wire logic rs_de,
  output logic rs_rx
);
  logic [7:0] rsp [$];

  // biased bus idles high between frames
  initial rs_rx = 1'b1;

  function automatic logic [15:0] crc16(input logic [7:0] q [$], input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  task automatic put_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rs_rx = f[i];
      repeat (BIT) @(negedge sys_clk);
    end
  endtask

  // sample mid-bit so edge jitter of the answer cannot matter
  task automatic get_byte();
    logic [7:0] b;
    repeat (BIT / 2) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge sys_clk);
      b[i] = rs_tx;
    end
    repeat (BIT) @(negedge sys_clk);
    rsp.push_back(b);
  endtask

  task automatic xfer(input logic [7:0] a, f, input logic [15:0] p, v);
    logic [7:0] q [$];
    logic [15:0] c;
    int n;
    q = '{a, f, p[15:8], p[7:0], v[15:8], v[7:0]};
    c = crc16(q, 6);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rsp.delete();
    // more than 3.5 bit times of silence before each request
    repeat (5 * BIT) @(negedge sys_clk);
    foreach (q[i]) put_byte(q[i]);
    n = 0;
    while (!rs_de && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    while (rs_de && n < 3000) begin
      if (!rs_tx) get_byte();
      else begin
        @(negedge sys_clk);
        n++;
      end
    end
  endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench of the cylinder holding-register bank
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] NODE = 8'h89;
  logic sys_clk, rst_b, rs_rx, rs_tx, rs_de;
  cmb_pkg::cmb_cfg_e cfg;
  logic [15:0] top_temp, feedback_temp, mid_temp, bottom_temp, charge_pct;
  logic immersion_on, relay_on, cleanse_required, heat_demand_on;
  int mismatches, compares;

  cmb_register_bank #(
    .BIT_CYCLES(16'h000A), .GAP_CYCLES(20'h0_0023), .SEC_CYCLES(28'h000_0008),
    .OUT_LIMIT_S(21'h0_0005), .BOT_LIMIT_S(21'h0_0009)
  ) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .rs_rx(rs_rx), .rs_tx(rs_tx), .rs_de(rs_de),
    .cfg(cfg), .top_temp(top_temp), .feedback_temp(feedback_temp), .mid_temp(mid_temp),
    .bottom_temp(bottom_temp), .charge_pct(charge_pct), .immersion_on(immersion_on),
    .relay_on(relay_on), .cleanse_required(cleanse_required),
    .heat_demand_on(heat_demand_on)
  );

  cmb_master_model u_m (
    .sys_clk(sys_clk), .rs_tx(rs_tx), .rs_de(rs_de), .rs_rx(rs_rx)
  );

  // ----------------------------------------------------------------
  // shared checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [15:0] s, input logic [15:0] e [$]);
    logic [15:0] c;
    u_m.xfer(NODE, 8'h03, s, 16'(e.size()));
    chk(16'(u_m.rsp.size()), 16'(2 * e.size() + 5));
    foreach (e[i]) chk({u_m.rsp[3 + 2 * i], u_m.rsp[4 + 2 * i]}, e[i]);
    c = u_m.crc16(u_m.rsp, u_m.rsp.size() - 2);
    chk({u_m.rsp[$], u_m.rsp[$ - 1]}, c);
  endtask

  // code 0 expects an echo, otherwise that exception code
  task automatic req(input logic [7:0] f, input logic [15:0] p, v, input logic [7:0] code);
    u_m.xfer(NODE, f, p, v);
    if (code != 0) chk({u_m.rsp[1], u_m.rsp[2]}, {f | 8'h80, code});
    else chk({u_m.rsp[4], u_m.rsp[5]}, v);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(16'({rs_de, immersion_on, relay_on, cleanse_required, heat_demand_on}), 0);
    rd(16'h0000, '{16'h0000, 16'h01F4, 16'h0064, 16'h0000, 16'h0000, 16'h0258, 16'h0111,
      16'h0222, 16'h0258, 16'h000A, 16'h0000, 16'h0089});
    $display("test reset done");
  endtask

  task automatic t_demand();
    req(8'h06, 16'h0001, 16'h01C2, 0);
    rd(16'h0001, '{16'h01C2});
    chk(16'(relay_on), 16'h0000);
    req(8'h06, 16'h0000, 16'h0001, 0);
    chk(16'(heat_demand_on), 16'h0001);
    chk(16'(relay_on), 16'h0001);
    req(8'h06, 16'h0002, 16'h0005, 0);
    chk(16'(relay_on), 16'h0000);
    req(8'h06, 16'h0002, 16'h0064, 0);
    $display("test demand done");
  endtask

  task automatic t_source();
    logic [15:0] e;
    logic ok;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 3; k++) begin
        cfg = cmb_pkg::cmb_cfg_e'(c);
        ok = (c == 0) || (c == 3 ? k == 0 : k < 2);
        e = ok ? 16'(k) : 16'h0000;
        req(8'h06, 16'h0003, 16'(k), 0);
        rd(16'h0003, '{e, 16'(c == 3 || e != 0)});
        chk({immersion_on, relay_on}, 16'({c == 3 || e != 0, c != 3 && e != 1}));
      end
    end
    $display("test source done");
  endtask

  task automatic t_refuse();
    req(8'h06, 16'h0005, 16'h0001, 8'h02);
    req(8'h06, 16'h000A, 16'h0001, 8'h02);
    req(8'h06, 16'h000C, 16'h0001, 8'h02);
    req(8'h03, 16'h0000, 16'h000D, 8'h03);
    req(8'h03, 16'h000B, 16'h0002, 8'h02);
    req(8'h04, 16'h0000, 16'h0001, 8'h01);
    req(8'h06, 16'h000B, 16'h0100, 8'h03);
    u_m.xfer(8'h42, 8'h03, 16'h0000, 16'h0001);
    chk(16'(u_m.rsp.size()), 16'h0000);
    // broadcast write acts silently
    u_m.xfer(8'h00, 8'h06, 16'h0001, 16'h0190);
    chk(16'(u_m.rsp.size()), 16'h0000);
    feedback_temp = 16'h0123;
    rd(16'h0001, '{16'h0190, 16'h0064, 16'h0000, 16'h0001, 16'h0258, 16'h0123});
    $display("test refuse done");
  endtask

  task automatic t_cleanse();
    bottom_temp = 16'h012C;
    repeat (55) @(negedge sys_clk);
    chk(16'(cleanse_required), 16'h0000);
    repeat (45) @(negedge sys_clk);
    chk(16'(cleanse_required), 16'h0001);
    rd(16'h000A, '{16'h0001});
    bottom_temp = 16'h0258;
    repeat (20) @(negedge sys_clk);
    chk(16'(cleanse_required), 16'h0001);
    charge_pct = 16'h0064;
    repeat (3) @(negedge sys_clk);
    chk(16'(cleanse_required), 16'h0000);
    charge_pct = 16'h000A;
    top_temp = 16'h012C;
    repeat (60) @(negedge sys_clk);
    chk(16'(cleanse_required), 16'h0001);
    top_temp = 16'h0258;
    charge_pct = 16'h0064;
    repeat (3) @(negedge sys_clk);
    chk(16'(cleanse_required), 16'h0000);
    $display("test cleanse done");
  endtask

  task automatic t_node();
    req(8'h06, 16'h000B, 16'h0042, 0);
    u_m.xfer(8'h42, 8'h03, 16'h000B, 16'h0001);
    chk({u_m.rsp[3], u_m.rsp[4]}, 16'h0042);
    u_m.xfer(NODE, 8'h03, 16'h000B, 16'h0001);
    chk(16'(u_m.rsp.size()), 16'h0000);
    $display("test node done");
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    mismatches = 0;
    compares = 0;
    rst_b = 1'b0;
    cfg = cmb_pkg::low_temp_heat_pump_config;
    top_temp = 16'h0258;
    feedback_temp = 16'h0111;
    mid_temp = 16'h0222;
    bottom_temp = 16'h0258;
    charge_pct = 16'h000A;
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_demand();
    t_source();
    t_refuse();
    t_cleanse();
    t_node();
    print_verdict();
  end

  // whole run needs roughly 74k cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
endmodule
